// ==== include/bsre_pkg.sv ====
// constants and types for the switch-and-button register entry block
package bsre_pkg;
  localparam int unsigned CLK_HZ          = 100000000;
  localparam int unsigned FLASH_HALF_MS   = 50;
  localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int unsigned FLASH_CNT_W     = 23;
  localparam logic [3:0]  FLASH_EDGES     = 4'h8;
  localparam logic [3:0]  CODE_CANCEL     = 4'hE;
  localparam logic [3:0]  CODE_ENTER      = 4'hF;
  localparam logic [3:0]  CODE_MAX_DIGIT  = 4'h9;
  localparam int unsigned REG_COUNT       = 29;
  localparam logic [6:0]  REG_LAST        = 7'h1C;
  localparam logic [6:0]  REG_BANK_BASE   = 7'h04;
  localparam logic [1:0]  CLKS_PER_BANK   = 2'h3;
  localparam logic [1:0]  REG_DIGITS      = 2'h2;
  localparam int unsigned SW_SERIAL_BIT   = 3;
  localparam int unsigned SW_NOTEST_BIT   = 3;

  typedef enum logic [3:0] {
    BSRE_ST_FLASH0  = 4'h0,
    BSRE_ST_I2C     = 4'h1,
    BSRE_ST_REFCHK  = 4'h2,
    BSRE_ST_LOAD    = 4'h3,
    BSRE_ST_IDLE    = 4'h4,
    BSRE_ST_ACK     = 4'h5,
    BSRE_ST_COMMIT  = 4'h6,
    BSRE_ST_PROG    = 4'h7,
    BSRE_ST_ERROR   = 4'h8,
    BSRE_ST_SERIAL  = 4'h9
  } bsre_state_type;
endpackage

// ==== core/bsre_sync3.sv ====
// three-stage input synchroniser with agreement on the last two stages
`timescale 1ns/1ps
module bsre_sync3 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // pins
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1Reg;
  logic [W-1:0] s2Reg;
  logic [W-1:0] s3Reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s1Reg <= '0;
      s2Reg <= '0;
      s3Reg <= '0;
    end else begin
      s1Reg <= pinIn;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
    end
  end

  // take a bit only once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2Reg[i] == s3Reg[i]) begin
          level[i] <= s3Reg[i];
        end
      end
    end
  end
endmodule

// ==== core/bsre_entry.sv ====
// switch-and-button register entry with start-up synthesiser check
`timescale 1ns/1ps
// How it works
// R1: switch-versus-serial editing mode is latched once at start-up only.
// R2: one digit per accepted press, sampled from the switches at that moment.
// R3: switch weights 8,4,2,1 form the four-bit digit code.
// R4: every accepted press starts a four-flash LED acknowledge.
// R5: presses during the flash sequence are ignored, acting as debounce.
// R6: code E discards the partial entry and restarts.
// R7: code F writes the register, stores it, programs synth if active bank.
// R8: twenty-nine 32-bit registers, numbered 0 to 28, kept nonvolatile.
// R9: leading digits pick the register, following digits form the value.
// R10: frequency register values are hertz.
// R11: committed entries for registers above 28 are silently dropped.
// R12: at power-up the LED flashes four times before other actions.
// R13: first check synth I2C answer, then the divided reference measurement.
// R14: a failed check lights the LED steadily and ignores all inputs.
// R15: button held at power-up skips the check and all synth access.
// R16: after a passed check, program the active bank frequencies.
// R17: with switch 1 on, no synth self-test and no GPS calibration.
// R18: operator keeps switches off at power-up except serial select.
// R19: operator grounds the GPS second pulse while programming.
// R20: exactly two register digits; value digits accumulate decimally, MSD first.
// R21: codes 10 to 13 are acknowledged but otherwise ignored.
module bsre_entry
  import bsre_pkg::*;
#(
  // flash half period in clock cycles
  parameter int unsigned HALF_CYC = FLASH_HALF_CYC
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // operator pins
  input  wire logic [3:0]  dipSwitch,
  input  wire logic        entryPushbutton,
  input  wire logic [2:0]  bankSelect,
  input  wire logic        gpsSecondPulseInput,
  output logic             ledOn,
  // synthesiser check and programming
  output logic             i2cProbeStart,
  input  wire logic        i2cProbeDone,
  input  wire logic        i2cProbeAck,
  output logic             refMeasStart,
  input  wire logic        refMeasDone,
  input  wire logic        refMeasOk,
  output logic             synthWrite,
  output logic [1:0]       synthOutput,
  output logic [31:0]      synthFreqHz,
  input  wire logic        synthBusy,
  // nonvolatile store
  output logic             nvWrite,
  output logic [4:0]       nvAddr,
  output logic [31:0]      nvData,
  // status
  output logic             serialMode,
  output logic             gpsCalEnable,
  output logic             synthBypass,
  output logic             errorLock
);
  logic [3:0]      swLvl;
  logic            btnLvl;
  logic [2:0]      bankLvl;
  logic [3:0]      inSyncOut;
  logic [3:0]      btnBankSync;
  bsre_state_type  stateReg;
  logic [FLASH_CNT_W-1:0] flashCntReg;
  logic [3:0]      flashEdgeReg;
  logic            btnPrevReg;
  logic            startupReg;
  logic [1:0]      regDigitsReg;
  logic [6:0]      regNumReg;
  logic [31:0]     valueReg;
  logic [3:0]      codeReg;
  logic [31:0]     regFile [0:REG_COUNT-1];
  logic [1:0]      loadIdxReg;
  logic [2:0]      activeBankReg;
  logic            pressEvt;
  logic            flashTick;
  logic            flashDone;
  logic [6:0]      bankBase;
  logic [6:0]      loadAddr;
  logic            goError;

  bsre_sync3 #(.W(4)) uSyncSw (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pinIn   (dipSwitch),
    .level   (inSyncOut)
  );
  bsre_sync3 #(.W(4)) uSyncBtn (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pinIn   ({entryPushbutton, bankSelect}),
    .level   (btnBankSync)
  );
  assign swLvl   = inSyncOut; // R3
  assign btnLvl  = btnBankSync[3];
  assign bankLvl = btnBankSync[2:0];

  // press edge and flash timing
  assign pressEvt  = btnLvl && !btnPrevReg;
  assign flashTick = (flashCntReg == FLASH_CNT_W'(HALF_CYC - 1));
  assign flashDone = flashTick && (flashEdgeReg == FLASH_EDGES - 4'h1);
  assign bankBase  = REG_BANK_BASE + 7'(activeBankReg) * 7'(CLKS_PER_BANK);
  assign loadAddr  = bankBase + 7'(loadIdxReg);
  // error entry, lit in the same cycle as the lock flag
  assign goError   = (stateReg == BSRE_ST_I2C && i2cProbeDone && !i2cProbeAck)
                     || (stateReg == BSRE_ST_REFCHK && refMeasDone && !refMeasOk);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      btnPrevReg <= 1'b0;
    end else begin
      btnPrevReg <= btnLvl;
    end
  end

  // flash counter, runs in both flash states
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      flashCntReg  <= '0;
      flashEdgeReg <= 4'h0;
    end else if (stateReg == BSRE_ST_FLASH0 || stateReg == BSRE_ST_ACK) begin
      if (flashTick) begin
        flashCntReg  <= '0;
        flashEdgeReg <= flashDone ? 4'h0 : flashEdgeReg + 4'h1;
      end else begin
        flashCntReg <= flashCntReg + FLASH_CNT_W'(1);
      end
    end else begin
      flashCntReg  <= '0;
      flashEdgeReg <= 4'h0;
    end
  end

  // start-up straps caught at the end of the power-up flash
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      startupReg   <= 1'b1;
      serialMode   <= 1'b0;
      synthBypass  <= 1'b0;
      gpsCalEnable <= 1'b0;
    end else if (startupReg && stateReg == BSRE_ST_FLASH0 && flashDone) begin
      startupReg   <= 1'b0;
      serialMode   <= swLvl[SW_SERIAL_BIT]; // R1
      synthBypass  <= btnLvl || swLvl[SW_NOTEST_BIT]; // R15 R17
      gpsCalEnable <= !swLvl[SW_NOTEST_BIT]; // R17
    end
  end

  // main sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stateReg      <= BSRE_ST_FLASH0;
      i2cProbeStart <= 1'b0;
      refMeasStart  <= 1'b0;
      synthWrite    <= 1'b0;
      synthOutput   <= 2'h0;
      synthFreqHz   <= 32'h0;
      loadIdxReg    <= 2'h0;
      activeBankReg <= 3'h0;
      codeReg       <= 4'h0;
      errorLock     <= 1'b0;
    end else begin
      i2cProbeStart <= 1'b0;
      refMeasStart  <= 1'b0;
      synthWrite    <= 1'b0;
      case (stateReg)
        BSRE_ST_FLASH0: begin
          if (flashDone) begin // R12
            activeBankReg <= bankLvl;
            if (swLvl[SW_SERIAL_BIT]) begin
              stateReg <= BSRE_ST_SERIAL; // R1
            end else if (btnLvl || swLvl[SW_NOTEST_BIT]) begin
              stateReg <= BSRE_ST_IDLE; // R15 R17
            end else begin
              i2cProbeStart <= 1'b1; // R13
              stateReg      <= BSRE_ST_I2C;
            end
          end
        end
        BSRE_ST_I2C: begin
          if (i2cProbeDone) begin
            if (i2cProbeAck) begin
              refMeasStart <= 1'b1; // R13
              stateReg     <= BSRE_ST_REFCHK;
            end else begin
              errorLock <= 1'b1; // R14
              stateReg  <= BSRE_ST_ERROR;
            end
          end
        end
        BSRE_ST_REFCHK: begin
          if (refMeasDone) begin
            if (refMeasOk) begin
              loadIdxReg <= 2'h0;
              stateReg   <= BSRE_ST_LOAD; // R16
            end else begin
              errorLock <= 1'b1; // R14
              stateReg  <= BSRE_ST_ERROR;
            end
          end
        end
        BSRE_ST_LOAD: begin
          if (!synthBusy && !synthWrite) begin
            synthWrite  <= 1'b1; // R16
            synthOutput <= loadIdxReg;
            synthFreqHz <= regFile[loadAddr[4:0]];
            if (loadIdxReg == CLKS_PER_BANK - 2'h1) begin
              stateReg <= BSRE_ST_IDLE;
            end else begin
              loadIdxReg <= loadIdxReg + 2'h1;
            end
          end
        end
        BSRE_ST_IDLE: begin
          if (pressEvt) begin // R2 R5
            codeReg  <= swLvl;
            stateReg <= BSRE_ST_ACK; // R4
          end
        end
        BSRE_ST_ACK: begin
          if (flashDone) begin // R5
            stateReg <= (codeReg == CODE_ENTER) ? BSRE_ST_COMMIT : BSRE_ST_IDLE;
          end
        end
        BSRE_ST_COMMIT: begin
          stateReg <= BSRE_ST_IDLE;
          if (regDigitsReg == REG_DIGITS && regNumReg <= REG_LAST // R11
              && !synthBypass && regNumReg >= bankBase
              && regNumReg < bankBase + 7'(CLKS_PER_BANK)) begin
            synthOutput <= 2'(regNumReg - bankBase); // R7
            synthFreqHz <= valueReg; // R10
            stateReg    <= BSRE_ST_PROG;
          end
        end
        BSRE_ST_PROG: begin
          if (!synthBusy) begin
            synthWrite <= 1'b1; // R7
            stateReg   <= BSRE_ST_IDLE;
          end
        end
        BSRE_ST_ERROR: begin
          stateReg <= BSRE_ST_ERROR; // R14
        end
        BSRE_ST_SERIAL: begin
          stateReg <= BSRE_ST_SERIAL;
        end
        default: begin
          stateReg <= BSRE_ST_FLASH0;
        end
      endcase
    end
  end

  // digit accumulation, applied when the acknowledge finishes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      regDigitsReg <= 2'h0;
      regNumReg    <= 7'h00;
      valueReg     <= 32'h0;
    end else if (stateReg == BSRE_ST_COMMIT) begin
      regDigitsReg <= 2'h0;
      regNumReg    <= 7'h00;
      valueReg     <= 32'h0;
    end else if (stateReg == BSRE_ST_ACK && flashDone) begin
      if (codeReg == CODE_CANCEL) begin
        regDigitsReg <= 2'h0; // R6
        regNumReg    <= 7'h00;
        valueReg     <= 32'h0;
      end else if (codeReg <= CODE_MAX_DIGIT) begin // R21
        if (regDigitsReg < REG_DIGITS) begin
          regNumReg    <= 7'(regNumReg * 7'h0A) + 7'(codeReg); // R9 R20
          regDigitsReg <= regDigitsReg + 2'h1;
        end else begin
          valueReg <= 32'(valueReg * 32'h0000000A) + 32'(codeReg); // R20
        end
      end
    end
  end

  // register file and nonvolatile store write
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      nvWrite <= 1'b0;
      nvAddr  <= 5'h00;
      nvData  <= 32'h0;
    end else begin
      nvWrite <= 1'b0;
      if (stateReg == BSRE_ST_COMMIT && regDigitsReg == REG_DIGITS
          && regNumReg <= REG_LAST) begin // R11
        regFile[regNumReg[4:0]] <= valueReg; // R8
        nvWrite <= 1'b1; // R7
        nvAddr  <= regNumReg[4:0];
        nvData  <= valueReg;
      end
    end
  end

  // led: flashes, steady on error
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ledOn <= 1'b0;
    end else if (stateReg == BSRE_ST_ERROR || goError) begin
      ledOn <= 1'b1; // R14
    end else if (stateReg == BSRE_ST_FLASH0 || stateReg == BSRE_ST_ACK) begin
      ledOn <= !flashEdgeReg[0]; // R4 R12
    end else begin
      ledOn <= 1'b0;
    end
  end
endmodule

// ==== bench/bsre_synth_model.sv ====
// synthesiser stand-in answering probe, measurement and write requests
`timescale 1ns/1ps
module bsre_synth_model #(
  parameter int unsigned DLY = 4
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // requests
  input  wire logic i2cProbeStart,
  input  wire logic refMeasStart,
  input  wire logic synthWrite,
  input  wire logic probeFail,
  // answers
  output logic      i2cProbeDone,
  output logic      i2cProbeAck,
  output logic      refMeasDone,
  output logic      refMeasOk,
  output logic      synthBusy
);
  int unsigned i2cCnt, measCnt, busyCnt;
  always @(posedge ref_clk) begin
    i2cProbeDone <= (i2cCnt == 1);
    refMeasDone  <= (measCnt == 1);
    // answer lines only mean something with done
    i2cProbeAck  <= (i2cCnt == 1) ? !probeFail : ~i2cProbeAck;
    refMeasOk    <= (measCnt == 1) ? 1'b1 : ~refMeasOk;
    synthBusy    <= synthWrite || (busyCnt > 1);
    if (!rst_b) begin
      i2cCnt  <= 0;
      measCnt <= 0;
      busyCnt <= 0;
    end else begin
      i2cCnt  <= i2cProbeStart ? DLY : (i2cCnt != 0 ? i2cCnt - 1 : 0);
      measCnt <= refMeasStart ? DLY : (measCnt != 0 ? measCnt - 1 : 0);
      busyCnt <= synthWrite ? DLY : (busyCnt != 0 ? busyCnt - 1 : 0);
    end
  end
endmodule

// ==== bench/bsre_entry_checker.sv ====
// concurrent checks on the register entry block ports
`timescale 1ns/1ps
module bsre_entry_checker
  import bsre_pkg::*;
#(
  parameter int unsigned HALF_CYC = FLASH_HALF_CYC
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // observed
  input  wire logic       ledOn,
  input  wire logic       i2cProbeStart,
  input  wire logic       i2cProbeDone,
  input  wire logic       i2cProbeAck,
  input  wire logic       refMeasStart,
  input  wire logic       synthWrite,
  input  wire logic       synthBypass,
  input  wire logic       nvWrite,
  input  wire logic [4:0] nvAddr,
  input  wire logic       serialMode,
  input  wire logic       errorLock
);
  localparam logic [31:0] FLASH_RUN = 32'(HALF_CYC * 8);
  logic [31:0] upCnt_reg;
  logic        i2cOk_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) upCnt_reg <= 32'h0;
    else if (upCnt_reg != 32'hFFFFFFFF) upCnt_reg <= upCnt_reg + 32'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) i2cOk_reg <= 1'b0;
    else if (i2cProbeDone && i2cProbeAck) i2cOk_reg <= 1'b1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_powerup_led_lit: assert property ($rose(rst_b) |-> ##[1:3] ledOn)
    else $error("led not lit after reset");
  chk_probe_after_flash: assert property (i2cProbeStart |-> upCnt_reg >= FLASH_RUN)
    else $error("probe before power-up flash ended");
  chk_meas_after_ack: assert property (refMeasStart |-> i2cOk_reg)
    else $error("measurement before probe answered");
  chk_error_led_steady: assert property (errorLock |-> ledOn && !nvWrite && !synthWrite)
    else $error("error state not steady");
  chk_error_held: assert property (errorLock |=> errorLock)
    else $error("error state left");
  chk_bypass_no_synth: assert property (synthBypass |-> !i2cProbeStart && !synthWrite)
    else $error("synth access while bypassed");
  chk_mode_latched: assert property (serialMode |=> serialMode)
    else $error("editing mode changed");
  chk_nv_reg_range: assert property (nvWrite |-> nvAddr <= REG_LAST[4:0])
    else $error("store to register above last");
  chk_nv_one_pulse: assert property (nvWrite |=> !nvWrite)
    else $error("store pulse too long");
  chk_commit_flashes: assert property (nvWrite |-> upCnt_reg >= FLASH_RUN * 4)
    else $error("store before enough acknowledged digits");
  cover property ($rose(rst_b) ##[1:3] ledOn);
  cover property (ledOn ##1 ledOn ##1 ledOn);
  cover property (ledOn && serialMode);
endmodule

// ==== bench/bsre_entry_tb.sv ====
// testbench for the register entry block
`timescale 1ns/1ps
module bsre_entry_tb;
  import bsre_pkg::*;
  localparam int unsigned HALF = 20;
  localparam int unsigned RUN  = HALF * 8;
  logic        ref_clk, rst_b, entryPushbutton, gpsSecondPulseInput, probeFail;
  logic [3:0]  dipSwitch;
  logic [2:0]  bankSelect;
  logic        ledOn, i2cProbeStart, i2cProbeDone, i2cProbeAck, refMeasStart;
  logic        refMeasDone, refMeasOk, synthWrite, synthBusy, nvWrite;
  logic [1:0]  synthOutput, lastOut;
  logic [31:0] synthFreqHz, nvData, lastNvData, lastFreq;
  logic [4:0]  nvAddr, lastNvAddr;
  logic        serialMode, gpsCalEnable, synthBypass, errorLock;
  int          error_cnt, n_tests;
  int          probeCnt, measCnt, wrCnt, nvCnt, p0, m0, w0, n0;
  logic [3:0]  codes [17] = '{4'h0, 4'h4, 4'h1, 4'h5, 4'hF,
                             4'h0, 4'h5, 4'hE, 4'h0, 4'h6, 4'hA, 4'h2, 4'hF,
                             4'h3, 4'h0, 4'h7, 4'hF};

  bsre_entry #(.HALF_CYC(HALF)) uut (.*);
  bsre_synth_model #(.DLY(6)) synth (.*);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // count synth and store pulses, keep the last payloads
  always @(posedge ref_clk) begin
    if (i2cProbeStart) probeCnt <= probeCnt + 1;
    if (refMeasStart) measCnt <= measCnt + 1;
    if (nvWrite) begin
      nvCnt      <= nvCnt + 1;
      lastNvAddr <= nvAddr;
      lastNvData <= nvData;
    end
    if (synthWrite) begin
      wrCnt    <= wrCnt + 1;
      lastOut  <= synthOutput;
      lastFreq <= synthFreqHz;
    end
  end

  task automatic expect_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic snap;
    p0 = probeCnt;
    m0 = measCnt;
    w0 = wrCnt;
    n0 = nvCnt;
  endtask

  task automatic do_reset(input logic btn, input logic [3:0] sw, input logic fail);
    @(posedge ref_clk);
    rst_b           <= 1'b0;
    entryPushbutton <= btn;
    dipSwitch       <= sw;
    probeFail       <= fail;
    repeat (2) @(posedge ref_clk);
    #1;
    expect_val(ledOn, 1'b0, "led lit in reset");
    @(posedge ref_clk);
    rst_b <= 1'b1;
    snap();
    repeat (6) @(posedge ref_clk);
    #1;
    expect_val(ledOn, 1'b1, "power-up flash missing");
    repeat (24) @(posedge ref_clk);
    #1;
    expect_val(ledOn, 1'b0, "power-up flash not blinking");
    repeat (RUN - 40) @(posedge ref_clk);
    #1;
    expect_val(probeCnt - p0, 32'h0, "probe during power-up flash");
  endtask

  task automatic press(input logic [3:0] code, input logic bnc);
    @(posedge ref_clk);
    dipSwitch <= code;
    repeat (2) @(posedge ref_clk);
    entryPushbutton <= 1'b1;
    repeat (8) @(posedge ref_clk);
    entryPushbutton <= 1'b0;
    repeat (30) @(posedge ref_clk);
    entryPushbutton <= bnc;
    repeat (8) @(posedge ref_clk);
    entryPushbutton <= 1'b0;
    repeat (RUN + 10) @(posedge ref_clk);
    #1;
  endtask

  task automatic run_codes(input int first, input int last);
    snap();
    for (int i = first; i <= last; i++) begin
      press(codes[i], i == 11);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rst_b               = 1'b0;
    entryPushbutton     = 1'b0;
    gpsSecondPulseInput = 1'b0;
    dipSwitch           = 4'h0;
    bankSelect          = 3'h0;
    probeFail           = 1'b0;
    error_cnt           = 0;
    n_tests             = 0;
    do_reset(1'b0, 4'h0, 1'b0);
    repeat (200) @(posedge ref_clk);
    #1;
    expect_val(probeCnt - p0, 32'h1, "probe count");
    expect_val(measCnt - m0, 32'h1, "measure count");
    expect_val(wrCnt - w0, 32'h3, "bank load count");
    expect_val({serialMode, synthBypass, errorLock, gpsCalEnable}, 4'h1, "status");
    run_codes(0, 4);
    expect_val(nvCnt - n0, 32'h1, "store count");
    expect_val(lastNvAddr, 5'h04, "store register");
    expect_val(lastNvData, 32'h0000000F, "store value");
    expect_val(wrCnt - w0, 32'h1, "synth write count");
    expect_val(lastOut, 2'h0, "synth output");
    expect_val(lastFreq, 32'h0000000F, "synth frequency");
    run_codes(5, 12);
    expect_val(nvCnt - n0, 32'h1, "store count after cancel");
    expect_val(lastNvAddr, 5'h06, "store register after cancel");
    expect_val(lastNvData, 32'h00000002, "value after ignored codes");
    expect_val(lastOut, 2'h2, "synth output after cancel");
    run_codes(13, 16);
    expect_val(nvCnt - n0, 32'h0, "store above last register");
    expect_val(wrCnt - w0, 32'h0, "synth write above last register");
    do_reset(1'b0, 4'h0, 1'b1);
    repeat (100) @(posedge ref_clk);
    #1;
    expect_val({errorLock, ledOn}, 2'h3, "error lock missing");
    expect_val(measCnt - m0, 32'h0, "measure after failed probe");
    run_codes(0, 4);
    expect_val(nvCnt - n0, 32'h0, "entry taken in error");
    expect_val({errorLock, ledOn}, 2'h3, "error lock left");
    do_reset(1'b1, 4'h0, 1'b0);
    repeat (30) @(posedge ref_clk);
    entryPushbutton <= 1'b0;
    repeat (30) @(posedge ref_clk);
    #1;
    expect_val(synthBypass, 1'b1, "bypass not taken");
    expect_val(probeCnt - p0, 32'h0, "probe while bypassed");
    run_codes(0, 4);
    expect_val(nvCnt - n0, 32'h1, "entry refused in bypass");
    expect_val(wrCnt - w0, 32'h0, "synth write in bypass");
    do_reset(1'b0, 4'h8, 1'b0);
    repeat (30) @(posedge ref_clk);
    #1;
    expect_val({serialMode, synthBypass, gpsCalEnable}, 3'h6, "serial start-up");
    expect_val(probeCnt - p0, 32'h0, "probe with switch 1 on");
    run_codes(0, 4);
    expect_val(serialMode, 1'b1, "editing mode changed");
    expect_val(nvCnt - n0, 32'h0, "button entry in serial mode");
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("[FAIL] %0t timeout", $time);
    finish_test();
  end
endmodule

bind bsre_entry bsre_entry_checker #(.HALF_CYC(HALF_CYC)) chk (.*);
